//--- src/dhi_device.sv
`timescale 1ns/1ps
`default_nettype none
module dhi_device #(
   parameter logic [5:0] ADDR_HI = dhi_pkg::I2C_ADDR_HI
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              ce,
   dhi_if.device                  bus,
   input  wire logic [7:0]        rd_byte,
   output logic                   rx_valid,
   output logic [7:0]             rx_byte,
   output logic                   rx_is_data,
   output logic                   rd_done,
   output dhi_pkg::dhi_mode_t     mode,
   output logic [6:0]             slave_address_bit
);
   import dhi_pkg::*;

   typedef enum logic [2:0] {
      I2C_IDLE = 3'h1,
      I2C_ADDR = 3'h2,
      I2C_DATA = 3'h4
   } dhi_i2c_t;

   logic       strap_done;
   logic       prev_e;
   logic       prev_w;
   logic       prev_scl;
   logic       prev_sda;
   logic [6:0] ser_sh;
   logic [2:0] ser_cnt;
   logic [6:0] i2c_sh;
   logic [3:0] bit_cnt;
   logic       ack_pend;
   dhi_i2c_t   i2c_st;

   logic       sel;
   logic       is_ser;
   logic       is_i2c;
   logic       is_68;
   logic       is_80;
   logic       scl;
   logic       sda_in;
   logic       scl_rise;
   logic       scl_fall;
   logic       i2c_start;
   logic       i2c_stop;
   logic       par_wr;
   logic       par_rd_act;
   logic       par_rd_end;
   logic       ser_last;
   logic       i2c_last;
   logic       addr_hit;

   // ***************************************************
   // decode of pins, all sampled on clk
   // ***************************************************
   assign sel    = ~bus.cs_n & strap_done;
   assign is_ser = (mode == MODE_SERIAL);
   assign is_i2c = (mode == MODE_I2C);
   assign is_68  = (mode == MODE_6800);
   assign is_80  = (mode == MODE_8080);
   assign scl    = bus.d_pin[PIN_SCLK];
   assign sda_in = bus.d_pin[PIN_SER_IN];
   assign scl_rise = ~prev_scl & scl;
   assign scl_fall = prev_scl & ~scl;
   // start and stop only count while the clock stays high
   assign i2c_start = is_i2c & sel & scl & prev_scl & prev_sda & ~sda_in;
   assign i2c_stop  = is_i2c & scl & prev_scl & ~prev_sda & sda_in;

   // parallel strobes; strobe pins are ignored outside parallel modes
   always_comb begin
      par_wr     = 1'b0;
      par_rd_act = 1'b0;
      par_rd_end = 1'b0;
      if (is_68 && sel) begin
         par_wr     = prev_e & ~bus.e_rd & ~bus.rw_wr;
         par_rd_act = bus.e_rd & bus.rw_wr;
         par_rd_end = prev_e & ~bus.e_rd & bus.rw_wr;
      end else if (is_80 && sel) begin
         par_wr     = ~prev_w & bus.rw_wr;
         par_rd_act = ~bus.e_rd;
         par_rd_end = ~prev_e & bus.e_rd;
      end
   end

   assign ser_last = is_ser & sel & scl_rise & (ser_cnt == BIT_LAST[2:0]);
   assign addr_hit = ({i2c_sh, sda_in} == {ADDR_HI, bus.dc, 1'b0});
   assign i2c_last = is_i2c & sel & scl_rise & ~i2c_start & ~i2c_stop
                     & (i2c_st == I2C_DATA) & (bit_cnt == BIT_LAST);

   // ***************************************************
   // strap capture, once after reset release
   // ***************************************************
   // straps are caught by the clock, never by the reset itself
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strap_done <= 1'b0;
         mode       <= MODE_SERIAL;
      end else if (ce && !strap_done) begin
         strap_done <= 1'b1;
         mode       <= dhi_decode({bus.strap_a, bus.strap_b});
      end
   end

   // slave address follows the data/command pin in i2c mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slave_address_bit <= 7'h00;
      end else if (ce) begin
         slave_address_bit <= {ADDR_HI, bus.dc};
      end
   end

   // ***************************************************
   // edge history
   // ***************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev_e   <= 1'b0;
         prev_w   <= 1'b1;
         prev_scl <= 1'b0;
         prev_sda <= 1'b1;
      end else if (ce) begin
         prev_e   <= bus.e_rd;
         prev_w   <= bus.rw_wr;
         prev_scl <= scl;
         prev_sda <= sda_in;
      end
   end

   // ***************************************************
   // four-wire serial receiver
   // ***************************************************
   // deselect restarts the byte, so a glitch costs one byte only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ser_sh  <= 7'h00;
         ser_cnt <= 3'h0;
      end else if (ce) begin
         if (!sel || !is_ser) begin
            ser_cnt <= 3'h0;
         end else if (scl_rise) begin
            ser_sh  <= {ser_sh[5:0], sda_in};
            ser_cnt <= ser_cnt + 3'h1;
         end
      end
   end

   // ***************************************************
   // i2c slave, write only
   // ***************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         i2c_st   <= I2C_IDLE;
         i2c_sh   <= 7'h00;
         bit_cnt  <= 4'h0;
         ack_pend <= 1'b0;
      end else if (ce) begin
         if (!is_i2c || !sel || i2c_stop) begin
            i2c_st   <= I2C_IDLE;
            ack_pend <= 1'b0;
         end else if (i2c_start) begin
            i2c_st   <= I2C_ADDR;
            bit_cnt  <= 4'h0;
            ack_pend <= 1'b0;
         end else if (scl_rise && i2c_st != I2C_IDLE) begin
            if (bit_cnt == BIT_ACK) begin
               bit_cnt  <= 4'h0;
               ack_pend <= 1'b0;
            end else begin
               i2c_sh  <= {i2c_sh[5:0], sda_in};
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == BIT_LAST) begin
                  if (i2c_st == I2C_ADDR) begin
                     ack_pend <= addr_hit;
                     i2c_st   <= addr_hit ? I2C_DATA : I2C_IDLE;
                  end else begin
                     ack_pend <= 1'b1;
                  end
               end
            end
         end
      end
   end

   // ***************************************************
   // pin drive
   // ***************************************************
   // read data is held for the whole strobe; the ack bit changes only
   // while the clock is low so it never looks like a start or stop
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus.dev_d  <= 8'h00;
         bus.dev_oe <= 8'h00;
      end else if (ce) begin
         if (is_i2c) begin
            bus.dev_d <= 8'h00;
            if (!sel || i2c_stop) begin
               bus.dev_oe <= 8'h00;
            end else if (scl_fall) begin
               bus.dev_oe <= 8'h00;
               bus.dev_oe[PIN_SDA_OUT] <= (bit_cnt == BIT_ACK) & ack_pend;
            end
         end else begin
            bus.dev_d  <= rd_byte;
            bus.dev_oe <= {8{par_rd_act}};
         end
      end
   end

   // ***************************************************
   // user-side byte stream
   // ***************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_valid   <= 1'b0;
         rx_byte    <= 8'h00;
         rx_is_data <= 1'b0;
         rd_done    <= 1'b0;
      end else if (ce) begin
         rx_valid <= par_wr | ser_last | i2c_last;
         rd_done  <= par_rd_end;
         if (par_wr) begin
            rx_byte    <= bus.d_pin;
            rx_is_data <= bus.dc;
         end else if (ser_last) begin
            rx_byte    <= {ser_sh, sda_in};
            rx_is_data <= bus.dc;
         end else if (i2c_last) begin
            rx_byte    <= {i2c_sh, sda_in};
            rx_is_data <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- src/dhi_pkg.sv
`default_nettype none
package dhi_pkg;
   // ***************************************************
   // strap codes, written {protocol_strap_a, protocol_strap_b}
   // ***************************************************
   localparam logic [1:0] STRAP_SERIAL = 2'h0;
   localparam logic [1:0] STRAP_6800   = 2'h1;
   localparam logic [1:0] STRAP_I2C    = 2'h2;
   localparam logic [1:0] STRAP_8080   = 2'h3;

   typedef enum logic [3:0] {
      MODE_SERIAL = 4'h1,
      MODE_I2C    = 4'h2,
      MODE_8080   = 4'h4,
      MODE_6800   = 4'h8
   } dhi_mode_t;

   // ***************************************************
   // pin roles and fixed values
   // ***************************************************
   localparam int         PIN_SCLK    = 0;
   localparam int         PIN_SER_IN  = 1;
   localparam int         PIN_SDA_OUT = 2;
   localparam logic [5:0] I2C_ADDR_HI = 6'h1e;  // plain default, upper bits
   localparam int         HOST_STEP_CYC = 4;    // host phase length
   localparam logic [3:0] BIT_LAST  = 4'h7;
   localparam logic [3:0] BIT_ACK   = 4'h8;

   // decode the strap pair into a one-hot mode
   function automatic dhi_mode_t dhi_decode(input logic [1:0] strap);
      dhi_mode_t m;
      m = MODE_SERIAL;
      unique case (strap)
         STRAP_I2C:  m = MODE_I2C;
         STRAP_8080: m = MODE_8080;
         STRAP_6800: m = MODE_6800;
         default:    m = MODE_SERIAL;
      endcase
      return m;
   endfunction
endpackage
`default_nettype wire

//--- src/dhi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dhi_if;
   logic       strap_a;
   logic       strap_b;
   logic       cs_n;
   logic       dc;
   logic       e_rd;
   logic       rw_wr;
   logic [7:0] host_d;
   logic [7:0] host_oe;
   logic [7:0] dev_d;
   logic [7:0] dev_oe;
   logic       i2c_joined;
   logic [7:0] d_pin;
   logic       sda;

   // ***************************************************
   // wire resolution: pull-ups, open-drain joined data line
   // ***************************************************
   assign sda = ~((host_oe[1] & ~host_d[1]) | (dev_oe[2] & ~dev_d[2])
                  | (dev_oe[1] & ~dev_d[1]));

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         d_pin[i] = host_oe[i] ? host_d[i] : (dev_oe[i] ? dev_d[i] : 1'b1);
      end
      if (i2c_joined) begin
         d_pin[1] = sda;
         d_pin[2] = sda;
      end
   end

   modport device (
      input  strap_a, strap_b, cs_n, dc, e_rd, rw_wr, d_pin,
      output dev_d, dev_oe
   );
   modport host (
      output strap_a, strap_b, cs_n, dc, e_rd, rw_wr, host_d, host_oe,
      output i2c_joined,
      input  d_pin
   );
endinterface
`default_nettype wire

//--- src/dhi_host.sv
`timescale 1ns/1ps
`default_nettype none
module dhi_host #(
   parameter int         STEP    = dhi_pkg::HOST_STEP_CYC,
   parameter logic [5:0] ADDR_HI = dhi_pkg::I2C_ADDR_HI
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   dhi_if.host             bus,
   input  wire logic [1:0] mode_sel,
   input  wire logic       addr_sel,
   input  wire logic       req_valid,
   input  wire logic       req_read,
   input  wire logic       req_is_data,
   input  wire logic [7:0] req_byte,
   output logic            req_ready,
   output logic            resp_valid,
   output logic [7:0]      resp_byte
);
   import dhi_pkg::*;

   typedef enum logic [7:0] {
      H_IDLE    = 8'h01,
      H_SETUP   = 8'h02,
      H_STROBE  = 8'h04,
      H_RECOVER = 8'h08,
      H_BIT_LO  = 8'h10,
      H_BIT_HI  = 8'h20,
      H_START   = 8'h40,
      H_STOP    = 8'h80
   } dhi_hst_t;

   dhi_hst_t   st;
   dhi_mode_t  hmode;
   logic [7:0] tmr;
   logic [17:0] frame;
   logic [4:0] nbits;
   logic       rd_op;
   logic       step_done;
   logic       is_i2c;

   assign step_done = (tmr == 8'(STEP - 1));
   assign is_i2c    = (hmode == MODE_I2C);

   // phase timer: every phase lasts STEP cycles
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tmr <= 8'h00;
      end else if (ce) begin
         tmr <= (st == H_IDLE || step_done) ? 8'h00 : tmr + 8'h01;
      end
   end

   // ***************************************************
   // transfer sequencer
   // ***************************************************
   // i2c reads are not offered; a read request there is sent as a write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st             <= H_IDLE;
         hmode          <= MODE_SERIAL;
         bus.strap_a    <= 1'b0;
         bus.strap_b    <= 1'b0;
         bus.cs_n       <= 1'b1;
         bus.dc         <= 1'b0;
         bus.e_rd       <= 1'b0;
         bus.rw_wr      <= 1'b0;
         bus.host_d     <= 8'h00;
         bus.host_oe    <= 8'h00;
         bus.i2c_joined <= 1'b0;
         frame          <= 18'h00000;
         nbits          <= 5'h00;
         rd_op          <= 1'b0;
         req_ready      <= 1'b0;
         resp_valid     <= 1'b0;
         resp_byte      <= 8'h00;
      end else if (ce) begin
         resp_valid <= 1'b0;
         unique case (st)
            H_IDLE: begin
               hmode          <= dhi_decode(mode_sel);
               bus.strap_a    <= mode_sel[1];
               bus.strap_b    <= mode_sel[0];
               bus.i2c_joined <= is_i2c;
               bus.cs_n       <= 1'b1;
               // idle strobe levels; serial modes tie them low
               bus.e_rd  <= (hmode == MODE_8080);
               bus.rw_wr <= (hmode == MODE_8080);
               if (hmode == MODE_SERIAL) begin
                  bus.host_oe <= 8'hfb;
                  bus.host_d  <= 8'h00;
               end else if (is_i2c) begin
                  bus.host_oe <= 8'hf9;
                  bus.host_d  <= 8'h01;
               end else begin
                  bus.host_oe <= 8'h00;
               end
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  bus.cs_n  <= 1'b0;
                  rd_op     <= req_read & ~is_i2c & (hmode != MODE_SERIAL);
                  bus.dc    <= is_i2c ? addr_sel : req_is_data;
                  if (hmode == MODE_SERIAL) begin
                     frame <= {req_byte, 10'h000};
                     nbits <= 5'd8;
                     st    <= H_BIT_LO;
                  end else if (is_i2c) begin
                     frame <= {ADDR_HI, addr_sel, 1'b0, 1'b1, req_byte, 1'b1};
                     nbits <= 5'd18;
                     st    <= H_START;
                  end else begin
                     bus.rw_wr   <= (hmode == MODE_6800) ? req_read
                                                         : 1'b1;
                     bus.host_d  <= req_byte;
                     bus.host_oe <= req_read ? 8'h00 : 8'hff;
                     st          <= H_SETUP;
                  end
               end
            end
            H_SETUP: if (step_done) begin
               if (hmode == MODE_6800) begin
                  bus.e_rd <= 1'b1;
               end else if (rd_op) begin
                  bus.e_rd <= 1'b0;
               end else begin
                  bus.rw_wr <= 1'b0;
               end
               st <= H_STROBE;
            end
            H_STROBE: if (step_done) begin
               if (rd_op) begin
                  resp_byte <= bus.d_pin;
               end
               bus.e_rd  <= (hmode == MODE_8080);
               bus.rw_wr <= (hmode == MODE_8080) | (bus.rw_wr & rd_op);
               st        <= H_RECOVER;
            end
            H_RECOVER: if (step_done) begin
               bus.cs_n   <= 1'b1;
               resp_valid <= rd_op;
               st         <= H_IDLE;
            end
            H_START: if (step_done) begin
               // first half: line released, clock high; then pull low
               if (!bus.host_oe[1]) begin
                  bus.host_oe[1] <= 1'b1;
                  bus.host_d[1]  <= 1'b0;
               end else begin
                  bus.host_d[0]  <= 1'b0;
                  bus.host_oe[1] <= ~frame[17];
                  st             <= H_BIT_LO;
               end
            end
            H_BIT_LO: begin
               bus.host_d[0] <= 1'b0;
               if (is_i2c) begin
                  bus.host_oe[1] <= ~frame[17];
                  bus.host_d[1]  <= 1'b0;
               end else begin
                  bus.host_d[1] <= frame[17];
               end
               if (step_done) begin
                  bus.host_d[0] <= 1'b1;
                  st            <= H_BIT_HI;
               end
            end
            H_BIT_HI: if (step_done) begin
               bus.host_d[0] <= 1'b0;
               frame         <= {frame[16:0], 1'b0};
               nbits         <= nbits - 5'd1;
               if (nbits != 5'd1) begin
                  st <= H_BIT_LO;
               end else if (is_i2c) begin
                  bus.host_oe[1] <= 1'b1;
                  st             <= H_STOP;
               end else begin
                  st <= H_RECOVER;
               end
            end
            H_STOP: if (step_done) begin
               if (!bus.host_d[0]) begin
                  bus.host_d[0] <= 1'b1;
               end else begin
                  bus.host_oe[1] <= 1'b0;
                  st             <= H_RECOVER;
               end
            end
            default: st <= H_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- test/dhi_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dhi_properties (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       strap_a,
   input wire logic       strap_b,
   input wire logic       cs_n,
   input wire logic       e_rd,
   input wire logic       rw_wr,
   input wire logic [7:0] dev_d,
   input wire logic [7:0] dev_oe,
   input wire logic [7:0] d_pin
);
   import dhi_pkg::*;

   // ***************************************************
   // read strobe decode, as the host presents it
   // ***************************************************
   logic [1:0] strap;
   logic       rd_6800;
   logic       rd_8080;
   logic       rd_any;

   // straps are static after reset, so the wire pair names the mode
   assign strap   = {strap_a, strap_b};
   assign rd_6800 = (strap == STRAP_6800) & e_rd & rw_wr & ~cs_n;
   assign rd_8080 = (strap == STRAP_8080) & ~e_rd & ~cs_n;
   assign rd_any  = rd_6800 | rd_8080;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // ***************************************************
   // bus drive and acknowledge checks
   // ***************************************************
   a_rd_drive_6800: assert property (rd_6800 |=> dev_oe == 8'hff)
      else $error("6800 read did not drive the data pins");
   a_rd_drive_8080: assert property (rd_8080 |=> dev_oe == 8'hff)
      else $error("8080 read did not drive the data pins");
   a_idle_no_drive: assert property (!rd_any |=>
      dev_oe[7:3] == 5'h00 && dev_oe[1:0] == 2'h0)
      else $error("data pins driven outside a read");
   a_unsel_no_drive: assert property ($past(cs_n) |->
      dev_oe == 8'h00)
      else $error("device drove pins while not selected");
   a_ack_pulls_low: assert property (dev_oe[2] && !dev_oe[7] |->
      dev_d[2] == 1'b0)
      else $error("acknowledge drive is not low");
   a_ack_on_fall: assert property ($rose(dev_oe[2]) && !dev_oe[7] |->
      $past(d_pin[0]) == 1'b0 && $past(d_pin[0], 2) == 1'b1)
      else $error("acknowledge not launched by a clock fall on pin 0");
   a_ack_release: assert property ($fell(dev_oe[2]) &&
      !$past(dev_oe[7]) |->
      $past(d_pin[0]) == 1'b0 && $past(d_pin[0], 2) == 1'b1)
      else $error("acknowledge not released on a clock fall");
   a_strobes_tied: assert property (!strap_b |->
      e_rd == 1'b0 && rw_wr == 1'b0)
      else $error("strobe pins not low in serial or i2c mode");

   // main traffic kinds seen at least once
   c_read_6800: cover property (rd_6800);
   c_read_8080: cover property (rd_8080);
   c_ack: cover property ($rose(dev_oe[2]) && !dev_oe[7]);
endmodule
`default_nettype wire

//--- test/display_host_interface_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(got, exp) begin check_count++; if ((got) !== (exp)) begin \
   fails++; $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module display_host_interface_select_tb;
   import dhi_pkg::*;
   logic       clk;
   logic       rstn;
   logic       dev_rstn;
   logic       ce;
   logic [1:0] mode_sel;
   logic       addr_sel;
   logic       req_valid;
   logic       req_read;
   logic       req_is_data;
   logic [7:0] req_byte;
   logic [7:0] rd_byte;
   logic       req_ready;
   logic       resp_valid;
   logic [7:0] resp_byte;
   logic       rx_valid;
   logic [7:0] rx_byte;
   logic       rx_is_data;
   logic       rd_done;
   dhi_mode_t  mode;
   logic [6:0] slave_address_bit;
   logic [3:0] rx_cnt, rd_cnt, ack_cnt;
   logic [7:0] rx_last, resp_last, wire_sh;
   logic       dc_last, sclk_q, ack_q;
   int         fails;
   int         check_count;

   dhi_if dhi_if_i ();
   dhi_device dhi_device_i (.clk(clk), .rstn(dev_rstn), .ce(ce),
      .bus(dhi_if_i), .rd_byte(rd_byte), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .rx_is_data(rx_is_data), .rd_done(rd_done),
      .mode(mode), .slave_address_bit(slave_address_bit));
   dhi_host dhi_host_i (.clk(clk), .rstn(rstn), .ce(ce), .bus(dhi_if_i),
      .mode_sel(mode_sel), .addr_sel(addr_sel), .req_valid(req_valid),
      .req_read(req_read), .req_is_data(req_is_data), .req_byte(req_byte),
      .req_ready(req_ready), .resp_valid(resp_valid),
      .resp_byte(resp_byte));
   dhi_properties dhi_properties_i (.clk(clk), .rstn(dev_rstn),
      .strap_a(dhi_if_i.strap_a), .strap_b(dhi_if_i.strap_b),
      .cs_n(dhi_if_i.cs_n), .e_rd(dhi_if_i.e_rd), .rw_wr(dhi_if_i.rw_wr),
      .dev_d(dhi_if_i.dev_d), .dev_oe(dhi_if_i.dev_oe),
      .d_pin(dhi_if_i.d_pin));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ***************************************************
   // monitors: pulses are one cycle wide, so count them here
   // ***************************************************
   always @(posedge clk) begin
      if (rx_valid === 1'b1) begin
         rx_cnt = rx_cnt + 4'h1;
         rx_last = rx_byte;
         dc_last = rx_is_data;
      end
      if (rd_done === 1'b1)
         rd_cnt = rd_cnt + 4'h1;
      if (resp_valid === 1'b1)
         resp_last = resp_byte;
      if (dhi_if_i.dev_oe[2] === 1'b1 && ack_q === 1'b0
          && dhi_if_i.dev_oe[7] === 1'b0)
         ack_cnt = ack_cnt + 4'h1;
      // serial shifter on the wire itself, msb arrives first
      if (mode_sel == STRAP_SERIAL && dhi_if_i.cs_n === 1'b0
          && sclk_q === 1'b0 && dhi_if_i.d_pin[0] === 1'b1)
         wire_sh = {wire_sh[6:0], dhi_if_i.d_pin[1]};
      sclk_q = dhi_if_i.d_pin[0];
      ack_q = dhi_if_i.dev_oe[2];
   end

   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // host leaves reset first so the straps are steady when the device wakes
   task automatic set_mode(input logic [1:0] m, input logic a);
      @(posedge clk);
      rstn <= 1'b0;
      dev_rstn <= 1'b0;
      mode_sel <= m;
      addr_sel <= a;
      rx_cnt = 4'h0;
      rd_cnt = 4'h0;
      ack_cnt = 4'h0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      dev_rstn <= 1'b1;
      repeat (3) @(negedge clk);
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         fails++;
         $display("[FAIL] %0t host never became ready", $time);
         summarize();
      end
   endtask

   // one request, held for the single edge that takes it
   task automatic send(input logic rd, input logic isd, input logic [7:0] b);
      wait_ready();
      @(posedge clk);
      req_valid <= 1'b1;
      req_read <= rd;
      req_is_data <= isd;
      req_byte <= b;
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      wait_ready();
      repeat (4) @(negedge clk);
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_6800();
      set_mode(STRAP_6800, 1'b0);
      `CHECK_EQ(mode, MODE_6800);
      send(1'b0, 1'b0, 8'ha5);
      `CHECK_EQ({rx_cnt, rx_last, dc_last}, {4'h1, 8'ha5, 1'b0});
      send(1'b0, 1'b1, 8'h5a);
      `CHECK_EQ({rx_cnt, rx_last, dc_last}, {4'h2, 8'h5a, 1'b1});
      rd_byte <= 8'hc3;
      send(1'b1, 1'b1, 8'h00);
      `CHECK_EQ({rx_cnt, rd_cnt, resp_last}, {4'h2, 4'h1, 8'hc3});
   endtask

   task automatic t_8080();
      set_mode(STRAP_8080, 1'b0);
      `CHECK_EQ(mode, MODE_8080);
      send(1'b0, 1'b1, 8'h3c);
      `CHECK_EQ({rx_cnt, rx_last, dc_last}, {4'h1, 8'h3c, 1'b1});
      send(1'b0, 1'b0, 8'hff);
      `CHECK_EQ({rx_cnt, rx_last, dc_last}, {4'h2, 8'hff, 1'b0});
      rd_byte <= 8'h69;
      send(1'b1, 1'b1, 8'h00);
      `CHECK_EQ({rx_cnt, rd_cnt, resp_last}, {4'h2, 4'h1, 8'h69});
   endtask

   task automatic t_serial();
      set_mode(STRAP_SERIAL, 1'b0);
      `CHECK_EQ(mode, MODE_SERIAL);
      send(1'b0, 1'b0, 8'h81);
      `CHECK_EQ(wire_sh, 8'h81);
      `CHECK_EQ({rx_cnt, rx_last, dc_last}, {4'h1, 8'h81, 1'b0});
      `CHECK_EQ(dhi_if_i.d_pin[7:3], 5'h00);
      send(1'b0, 1'b1, 8'h7e);
      `CHECK_EQ({rx_cnt, rx_last, dc_last}, {4'h2, 8'h7e, 1'b1});
   endtask

   // both address-select levels, each acked for address and data
   task automatic t_i2c();
      for (int s = 0; s < 2; s++) begin
         set_mode(STRAP_I2C, s[0]);
         `CHECK_EQ(mode, MODE_I2C);
         send(1'b0, 1'b0, 8'h96);
         `CHECK_EQ({rx_cnt, rx_last, dc_last}, {4'h1, 8'h96, 1'b1});
         `CHECK_EQ(ack_cnt, 4'h2);
         `CHECK_EQ(slave_address_bit, {I2C_ADDR_HI, s[0]});
      end
   endtask

   // main sequence; only ce is tied
   initial begin
      rstn = 1'b0;
      dev_rstn = 1'b0;
      ce = 1'b1;
      mode_sel = STRAP_SERIAL;
      addr_sel = 1'b0;
      req_valid = 1'b0;
      req_read = 1'b0;
      req_is_data = 1'b0;
      req_byte = 8'h00;
      rd_byte = 8'h00;
      fails = 0;
      check_count = 0;
      sclk_q = 1'b1;
      ack_q = 1'b0;
      wire_sh = 8'h00;
      t_6800();
      t_8080();
      t_serial();
      t_i2c();
      summarize();
   end
endmodule
`default_nettype wire
